// *** rpet_consts.vh ***
// Constants for the radio packet event timing block
`ifndef RPET_CONSTS_VH
`define RPET_CONSTS_VH
`define RPET_CLK_MHZ 50
// Register offsets
`define RPET_ADDR_ADC_CLK 8'h08
`define RPET_ADDR_IWAIT_LO 8'h17
`define RPET_ADDR_IWAIT_HI 8'h18
`define RPET_ADDR_PEND0 8'h40
`define RPET_ADDR_PEND1 8'h41
`define RPET_ADDR_PEND2 8'h42
`define RPET_ADDR_PEND3 8'h43
`define RPET_ADDR_MASK0 8'h44
`define RPET_ADDR_MASK1 8'h45
`define RPET_ADDR_MASK2 8'h46
`define RPET_ADDR_MASK3 8'h47
`define RPET_ADDR_CTRL 8'h48
`define RPET_ADDR_AVG 8'h49
`define RPET_ADDR_IRQ 8'h4A
// Field positions
`define RPET_ADC_CLK_BIT 4
`define RPET_CTRL_FEC_BIT 0
`define RPET_CTRL_IDET_BIT 1
`define RPET_CTRL_RATE_LO 2
`define RPET_CTRL_RATE_HI 3
// Reset values
`define RPET_RST_BYTE 8'h00
`define RPET_RST_MASK 32'h0000_0000
`define RPET_RST_AVG 8'h08
// Interrupt numbers
`define RPET_INT_CCA 8
`define RPET_INT_RF 10
`define RPET_INT_TXLEN 13
`define RPET_INT_RXFE 14
`define RPET_INT_TXFE 15
`define RPET_INT_TXDONE 16
`define RPET_INT_RXDONE 18
`define RPET_INT_CRC 20
`define RPET_INT_TXACC 22
`define RPET_INT_ACK 24
`define RPET_INT_PLL 25
// Times in ns, cycles derived at the clock rate
`define RPET_NS2CYC(t) (((t) * `RPET_CLK_MHZ) / 1000)
`define RPET_T_ADC18_NS 17700
`define RPET_T_ADC20_NS 16000
`define RPET_T_TXON_IDLE_NS 122000
`define RPET_T_TXON_RX_NS 89000
`define RPET_T_RXON_IDLE_NS 136000
`define RPET_T_RXON_TX_NS 142000
`define RPET_T_OFF_TX_NS 410000
`define RPET_T_OFF_RX_NS 11000
`define RPET_T_FOFF_RX_NS 10000
`define RPET_T_TXDLY_NS 154000
`define RPET_T_TXDLY_FEC_NS 224000
`define RPET_T_RXDLY_NS 5000
`define RPET_T_RXDLY_FEC_NS 315000
`define RPET_T_ACK_NS 92000
// Symbol time 2.5 us at 400 kbps is the base tick
`define RPET_T_TICK_NS 2500
`define RPET_TICKS_50K 8
`define RPET_TICKS_100K 4
`define RPET_TICKS_200K 2
`define RPET_TICKS_400K 1
`endif

// *** rpet_delay.v ***
// One-shot delay timer that pulses when a loaded cycle count expires
`timescale 1ns/1ps
module rpet_delay (
   clk,
   rst_n,
   start,
   load_count,
   cancel,
   done
);
   input wire clk;
   input wire rst_n;
   input wire start;
   input wire [31:0] load_count;
   input wire cancel;
   output reg done;
   reg [31:0] count_reg;
   reg busy_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 32'h0000_0000;
         busy_reg <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (cancel) begin
            busy_reg <= 1'b0;
         end else if (start) begin
            // Restart wins so a new reference point replaces the old one
            count_reg <= (load_count == 32'h0000_0000) ? 32'h0000_0001 : load_count;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (count_reg == 32'h0000_0001) begin
               busy_reg <= 1'b0;
               done <= 1'b1;
            end
            count_reg <= count_reg - 32'h0000_0001;
         end
      end
   end
endmodule // rpet_delay

// *** rpet_event_timing.v ***
// Packet handler event timing and pending interrupt bits
// Overview of operation
// [R01] Host loads the whole transmit packet before issuing transmit-on.
// [R02] Assessment done after (averaging + idle wait + 2) conversions, normal or idle.
// [R03] Busy channel in idle-detect mode: done after (averaging + 2) conversions.
// [R04] A conversion is 17.7 us at 1.8 MHz, 16 us at 2.0 MHz.
// [R05] Host arms abort timer under diversity; completion may never come.
// [R06] Transition done: tx-on 122/89 us, rx-on 136/142 us by origin state.
// [R07] Off done 410 us from tx, 11 us from rx; forced 410/10 us.
// [R08] Transmit length error raised when host writes a bad length.
// [R09] Receive buffer error on third packet, overflow or underflow.
// [R10] Transmit buffer error on third packet, write overflow or send underflow.
// [R11] Tx done without coding: all bits times symbol time plus 154 us.
// [R12] Tx done with coding: header bits plus doubled rest, plus 224 us.
// [R13] Rx done after length-to-check bits, doubled coded, plus 5 or 315 us.
// [R14] Check error raised at rx-done moment with same delay.
// [R15] Transmit request accepted once whole packet is in that buffer.
// [R16] Acknowledge ready 92 us after receive completion.
// [R17] PLL unlock reported only while amplifier or receiver is enabled.
// [R18] Symbol time 10 us at 100 kbps; 20, 5, 2.5 at other rates.
// [R19] Events latch while masked; interrupt rises once mask is lifted.
// [R20] Each source has a pending bit by number; buffer pairs adjacent.
`timescale 1ns/1ps
`include "rpet_consts.vh"
module rpet_event_timing (
   clk,
   reset_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   cca_start,
   cca_busy,
   cmd_tx_on,
   cmd_rx_on,
   cmd_off,
   cmd_force_off,
   state_tx,
   state_rx,
   tx_write_bad_len,
   tx_full_written,
   tx_buf_sel,
   tx_third_packet,
   tx_overflow,
   tx_underflow,
   tx_bits,
   rx_sfd,
   rx_buf_sel,
   rx_bits,
   rx_crc_bad,
   rx_third_packet,
   rx_overflow,
   rx_underflow,
   pa_enabled,
   rx_enabled,
   pll_unlock_pin,
   irq
);
   input wire clk;
   input wire reset_n;
   input wire [7:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   input wire cca_start;
   input wire cca_busy;
   input wire cmd_tx_on;
   input wire cmd_rx_on;
   input wire cmd_off;
   input wire cmd_force_off;
   input wire state_tx;
   input wire state_rx;
   input wire tx_write_bad_len;
   input wire tx_full_written;
   input wire tx_buf_sel;
   input wire tx_third_packet;
   input wire tx_overflow;
   input wire tx_underflow;
   input wire [15:0] tx_bits;
   input wire rx_sfd;
   input wire rx_buf_sel;
   input wire [15:0] rx_bits;
   input wire rx_crc_bad;
   input wire rx_third_packet;
   input wire rx_overflow;
   input wire rx_underflow;
   input wire pa_enabled;
   input wire rx_enabled;
   input wire pll_unlock_pin;
   output reg irq;

   // Reset release
   // Synchronised release, so all flops leave reset on one edge
   reg rst_s1_reg;
   reg rst_n_reg;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // Unlock pin is asynchronous; three stages, change taken when last two agree
   reg [2:0] pll_sync_reg;
   reg pll_level_reg;
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pll_sync_reg <= 3'h0;
         pll_level_reg <= 1'b0;
      end else begin
         pll_sync_reg <= {pll_sync_reg[1:0], pll_unlock_pin};
         // Disagreeing stages keep the last agreed level
         if (pll_sync_reg[1] == pll_sync_reg[2]) begin
            pll_level_reg <= pll_sync_reg[2];
         end
      end
   end

   // Registers
   reg [7:0] adc_clock_select_reg;
   reg [7:0] idle_wait_low_reg;
   reg [7:0] idle_wait_high_reg;
   reg [7:0] ctrl_reg;
   reg [7:0] avg_reg;
   reg [31:0] mask_reg;
   reg [31:0] pend_reg;
   reg [31:0] pend_next;
   reg [31:0] set_vec;
   reg [31:0] clr_vec;

   wire fec_on = ctrl_reg[`RPET_CTRL_FEC_BIT];
   wire [1:0] rate_sel = ctrl_reg[`RPET_CTRL_RATE_HI:`RPET_CTRL_RATE_LO];

   // Conversion time by converter clock selection [R04]
   wire [31:0] adc_cyc = adc_clock_select_reg[`RPET_ADC_CLK_BIT] ?
      `RPET_NS2CYC(`RPET_T_ADC20_NS) : `RPET_NS2CYC(`RPET_T_ADC18_NS);
   wire [31:0] iwait = {16'h0000, idle_wait_high_reg, idle_wait_low_reg};
   wire [31:0] avg_w = {24'h0000_00, avg_reg};
   // Busy result in idle-detect mode drops the idle wait [R02] [R03]
   // Latched at start so a later busy change cannot alter the delay
   reg cca_busy_reg;
   wire [31:0] cca_conv = (ctrl_reg[`RPET_CTRL_IDET_BIT] && cca_busy_reg) ?
      (avg_w + 32'h0000_0002) : (avg_w + iwait + 32'h0000_0002);
   wire [31:0] cca_cyc = cca_conv * adc_cyc;

   // Symbol time in 2.5 us ticks [R18]
   reg [31:0] sym_ticks;
   always @* begin
      case (rate_sel)
         2'd0: sym_ticks = `RPET_TICKS_50K;
         2'd1: sym_ticks = `RPET_TICKS_100K;
         2'd2: sym_ticks = `RPET_TICKS_200K;
         default: sym_ticks = `RPET_TICKS_400K;
      endcase
   end
   wire [31:0] sym_cyc = sym_ticks * `RPET_NS2CYC(`RPET_T_TICK_NS);

   // Host supplies tx_bits as preamble-to-check, already doubled for coding [R11] [R12]
   wire [31:0] tx_cyc = ({16'h0000, tx_bits} * sym_cyc) + (fec_on ?
      `RPET_NS2CYC(`RPET_T_TXDLY_FEC_NS) : `RPET_NS2CYC(`RPET_T_TXDLY_NS)); // [R01]
   // Receive length comes in uncoded; coding doubles it here
   wire [31:0] rx_len = fec_on ? {15'h0000, rx_bits, 1'b0} : {16'h0000, rx_bits};
   wire [31:0] rx_cyc = (rx_len * sym_cyc) + (fec_on ?
      `RPET_NS2CYC(`RPET_T_RXDLY_FEC_NS) : `RPET_NS2CYC(`RPET_T_RXDLY_NS)); // [R13] [R14]

   // Transition time by command and origin state [R06] [R07]
   // Off from idle has no figure of its own; the receive one is used
   reg [31:0] rf_cyc;
   always @* begin
      rf_cyc = 32'h0000_0001;
      if (cmd_tx_on) begin
         rf_cyc = state_rx ? `RPET_NS2CYC(`RPET_T_TXON_RX_NS) :
            `RPET_NS2CYC(`RPET_T_TXON_IDLE_NS);
      end else if (cmd_rx_on) begin
         rf_cyc = state_tx ? `RPET_NS2CYC(`RPET_T_RXON_TX_NS) :
            `RPET_NS2CYC(`RPET_T_RXON_IDLE_NS);
      end else if (cmd_off) begin
         rf_cyc = state_tx ? `RPET_NS2CYC(`RPET_T_OFF_TX_NS) :
            `RPET_NS2CYC(`RPET_T_OFF_RX_NS);
      end else if (cmd_force_off) begin
         rf_cyc = state_tx ? `RPET_NS2CYC(`RPET_T_OFF_TX_NS) :
            `RPET_NS2CYC(`RPET_T_FOFF_RX_NS);
      end
   end
   wire rf_cmd = cmd_tx_on | cmd_rx_on | cmd_off | cmd_force_off;

   // Start of assessment loads the delay one cycle later with latched result
   reg cca_go_reg;
   reg tx_sel_reg;
   reg rx_sel_reg;
   reg crc_bad_reg;
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cca_busy_reg <= 1'b0;
         cca_go_reg <= 1'b0;
         tx_sel_reg <= 1'b0;
         rx_sel_reg <= 1'b0;
         crc_bad_reg <= 1'b0;
      end else begin
         cca_go_reg <= cca_start;
         if (cca_start) begin
            cca_busy_reg <= cca_busy;
         end
         if (cmd_tx_on) begin
            tx_sel_reg <= tx_buf_sel;
         end
         if (rx_sfd) begin
            rx_sel_reg <= rx_buf_sel;
         end
         if (rx_crc_bad) begin
            crc_bad_reg <= 1'b1;
         end else if (rx_sfd) begin
            crc_bad_reg <= 1'b0;
         end
      end
   end

   wire cca_done;
   wire rf_done;
   wire tx_done;
   wire rx_done;
   wire ack_done;
   // Diversity abort is host-side; an unfinished assessment is simply never done [R05]
   rpet_delay u_cca (.clk(clk), .rst_n(rst_n_reg), .start(cca_go_reg),
      .load_count(cca_cyc), .cancel(1'b0), .done(cca_done)); // [R02] [R03]
   rpet_delay u_rf (.clk(clk), .rst_n(rst_n_reg), .start(rf_cmd),
      .load_count(rf_cyc), .cancel(1'b0), .done(rf_done)); // [R06] [R07]
   // Forced off abandons a frame in flight, so its timers stop
   rpet_delay u_tx (.clk(clk), .rst_n(rst_n_reg), .start(cmd_tx_on),
      .load_count(tx_cyc), .cancel(cmd_force_off), .done(tx_done)); // [R11] [R12]
   rpet_delay u_rx (.clk(clk), .rst_n(rst_n_reg), .start(rx_sfd),
      .load_count(rx_cyc), .cancel(cmd_force_off), .done(rx_done)); // [R13]
   rpet_delay u_ack (.clk(clk), .rst_n(rst_n_reg), .start(rx_done),
      .load_count(`RPET_NS2CYC(`RPET_T_ACK_NS)), .cancel(cmd_force_off),
      .done(ack_done)); // [R16]

   // Each buffer owns one bit of every pair, the first buffer the even bit [R20]
   wire [1:0] buf_tx_done;
   wire [1:0] buf_rx_done;
   wire [1:0] buf_crc_err;
   wire [1:0] buf_tx_acc;
   genvar bi;
   generate
      for (bi = 0; bi < 2; bi = bi + 1) begin : g_buf
         localparam [0:0] buf_id = bi;
         assign buf_tx_done[bi] = tx_done && (tx_sel_reg == buf_id); // [R11] [R12]
         assign buf_rx_done[bi] = rx_done && !crc_bad_reg && (rx_sel_reg == buf_id); // [R13]
         assign buf_crc_err[bi] = rx_done && crc_bad_reg && (rx_sel_reg == buf_id); // [R14]
         assign buf_tx_acc[bi] = tx_full_written && (tx_buf_sel == buf_id); // [R15]
      end
   endgenerate

   // Event sources by interrupt number [R20]
   wire pll_active = (state_tx && pa_enabled) || (state_rx && rx_enabled);
   always @* begin
      set_vec = 32'h0000_0000;
      set_vec[`RPET_INT_CCA] = cca_done;
      set_vec[`RPET_INT_RF] = rf_done;
      set_vec[`RPET_INT_TXLEN] = tx_write_bad_len; // [R08]
      set_vec[`RPET_INT_RXFE] = rx_third_packet | rx_overflow | rx_underflow; // [R09]
      set_vec[`RPET_INT_TXFE] = tx_third_packet | tx_overflow | tx_underflow; // [R10]
      set_vec[`RPET_INT_TXDONE +: 2] = buf_tx_done;
      set_vec[`RPET_INT_RXDONE +: 2] = buf_rx_done;
      set_vec[`RPET_INT_CRC +: 2] = buf_crc_err; // [R14]
      set_vec[`RPET_INT_TXACC +: 2] = buf_tx_acc; // [R15]
      set_vec[`RPET_INT_ACK] = ack_done;
      // Re-set every cycle while unlocked and active
      set_vec[`RPET_INT_PLL] = pll_level_reg && pll_active; // [R17]
   end

   // Clear by writing one to a pending byte
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_clr
         always @* begin
            clr_vec[gi*8 +: 8] = (reg_wr && reg_addr == (`RPET_ADDR_PEND0 + gi)) ?
               reg_wdata : 8'h00;
         end
      end
   endgenerate

   always @* begin
      // Set wins over clear; masking never blocks the latch [R19]
      pend_next = (pend_reg & ~clr_vec) | set_vec;
   end

   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         adc_clock_select_reg <= `RPET_RST_BYTE;
         idle_wait_low_reg <= `RPET_RST_BYTE;
         idle_wait_high_reg <= `RPET_RST_BYTE;
         ctrl_reg <= `RPET_RST_BYTE;
         avg_reg <= `RPET_RST_AVG;
         mask_reg <= `RPET_RST_MASK;
         pend_reg <= `RPET_RST_MASK;
         irq <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         pend_reg <= pend_next;
         // Mask bit one enables; interrupt follows one cycle after the mask register loads on unmask [R19]
         irq <= |(pend_next & mask_reg);
         // Pending bytes clear through clr_vec, not here
         if (reg_wr) begin
            case (reg_addr)
               `RPET_ADDR_ADC_CLK: adc_clock_select_reg <= reg_wdata; // [R04]
               `RPET_ADDR_IWAIT_LO: idle_wait_low_reg <= reg_wdata;
               `RPET_ADDR_IWAIT_HI: idle_wait_high_reg <= reg_wdata;
               `RPET_ADDR_MASK0: mask_reg[7:0] <= reg_wdata;
               `RPET_ADDR_MASK1: mask_reg[15:8] <= reg_wdata;
               `RPET_ADDR_MASK2: mask_reg[23:16] <= reg_wdata;
               `RPET_ADDR_MASK3: mask_reg[31:24] <= reg_wdata;
               `RPET_ADDR_CTRL: ctrl_reg <= {4'h0, reg_wdata[3:0]};
               `RPET_ADDR_AVG: avg_reg <= reg_wdata;
               default: ;
            endcase
         end
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `RPET_ADDR_ADC_CLK: reg_rdata <= adc_clock_select_reg;
               `RPET_ADDR_IWAIT_LO: reg_rdata <= idle_wait_low_reg;
               `RPET_ADDR_IWAIT_HI: reg_rdata <= idle_wait_high_reg;
               `RPET_ADDR_PEND0: reg_rdata <= pend_reg[7:0];
               `RPET_ADDR_PEND1: reg_rdata <= pend_reg[15:8];
               `RPET_ADDR_PEND2: reg_rdata <= pend_reg[23:16];
               `RPET_ADDR_PEND3: reg_rdata <= pend_reg[31:24];
               `RPET_ADDR_MASK0: reg_rdata <= mask_reg[7:0];
               `RPET_ADDR_MASK1: reg_rdata <= mask_reg[15:8];
               `RPET_ADDR_MASK2: reg_rdata <= mask_reg[23:16];
               `RPET_ADDR_MASK3: reg_rdata <= mask_reg[31:24];
               `RPET_ADDR_CTRL: reg_rdata <= ctrl_reg;
               `RPET_ADDR_AVG: reg_rdata <= avg_reg;
               `RPET_ADDR_IRQ: reg_rdata <= {7'h00, irq};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // rpet_event_timing

// *** rpet_event_timing_monitor.sv ***
// Port-level checks for the packet event timing block
`timescale 1ns/1ps
module rpet_event_timing_monitor (
   input logic clk,
   input logic reset_n,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic irq,
   input logic cmd_tx_on,
   input logic state_tx,
   input logic state_rx,
   input logic tx_write_bad_len,
   input logic tx_full_written,
   input logic tx_buf_sel,
   input logic tx_third_packet,
   input logic rx_overflow,
   input logic pll_unlock_pin,
   input logic rx_enabled
);
   logic [31:0] msk_reg;
   // Shadow of the mask bytes, so irq can be tied to its causes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) msk_reg <= 32'h0000_0000;
      else if (reg_wr && reg_addr[7:2] == 6'h11) msk_reg[reg_addr[1:0]*8 +: 8] <= reg_wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_irq_masked: assert property ((msk_reg == 32'h0000_0000) [*3] |-> !irq)
      else $error("irq with all sources masked");
   a_len_err: assert property (tx_write_bad_len && msk_reg[13] |-> ##[1:2] irq)
      else $error("length error did not raise irq");
   a_tx_buf_err: assert property (tx_third_packet && msk_reg[15] |-> ##[1:2] irq)
      else $error("transmit buffer error did not raise irq");
   a_rx_buf_err: assert property (rx_overflow && msk_reg[14] |-> ##[1:2] irq)
      else $error("receive buffer error did not raise irq");
   a_tx_accept: assert property (tx_full_written && msk_reg[22 + tx_buf_sel] |-> ##[1:2] irq)
      else $error("accept event did not raise irq");
   a_pll_report: assert property ((state_rx && rx_enabled && pll_unlock_pin
      && msk_reg[25]) [*6] |-> irq)
      else $error("unlock not reported while receiving");
   a_rf_not_early: assert property (cmd_tx_on && !state_tx && !state_rx && !irq &&
      msk_reg == 32'h0000_0400 |=> !irq [*8])
      else $error("transition done too early");
   cover property ($rose(irq));
   cover property (cmd_tx_on && msk_reg[10]);
   cover property (tx_full_written && tx_buf_sel);
endmodule // rpet_event_timing_monitor

// *** rpet_host_model.sv ***
// Host that loads a packet and then issues transmit-on
`timescale 1ns/1ps
module rpet_host_model (
   input logic clk,
   input logic go,
   input logic sel,
   input logic [15:0] bits,
   output logic tx_full_written,
   output logic tx_buf_sel,
   output logic [15:0] tx_bits,
   output logic cmd_tx_on
);
   initial begin
      tx_full_written = 1'b0;
      cmd_tx_on = 1'b0;
      tx_buf_sel = 1'b0;
      tx_bits = 16'h0000;
   end
   always @(posedge clk) begin
      tx_full_written <= go;
      cmd_tx_on <= tx_full_written;
      // Qualifiers only mean something around the two pulses
      tx_buf_sel <= (go || tx_full_written) ? sel : ~sel;
      tx_bits <= (go || tx_full_written) ? bits : ~bits;
   end
endmodule // rpet_host_model

// *** test_radio_packet_event_timing.sv ***
// Self-checking bench for the packet event timing block
`timescale 1ns/1ps
`include "rpet_consts.vh"
module test_radio_packet_event_timing;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, cca_busy = 0, state_tx = 0;
   logic state_rx = 0, rx_sel = 0, pa_en = 0, rx_en = 0, pll = 0, h_go = 0, h_sel = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, rv;
   logic [15:0] rx_bits = 0, h_bits = 0, txbits;
   logic [12:0] ev = 0;
   logic [7:0] reg_rdata;
   logic irq, cmd_tx_on, txfw, txsel;
   integer n_mismatch = 0, total_checks = 0, i, c;
   always #10 clk = ~clk;
   rpet_host_model u_host (.clk(clk), .go(h_go), .sel(h_sel), .bits(h_bits),
      .tx_full_written(txfw), .tx_buf_sel(txsel), .tx_bits(txbits), .cmd_tx_on(cmd_tx_on));
   rpet_event_timing dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cca_start(ev[0]), .cca_busy(cca_busy), .cmd_tx_on(cmd_tx_on), .cmd_rx_on(ev[1]),
      .cmd_off(ev[2]), .cmd_force_off(ev[3]), .state_tx(state_tx), .state_rx(state_rx),
      .tx_write_bad_len(ev[4]), .tx_full_written(txfw), .tx_buf_sel(txsel),
      .tx_third_packet(ev[5]), .tx_overflow(ev[6]), .tx_underflow(ev[7]), .tx_bits(txbits),
      .rx_sfd(ev[8]), .rx_buf_sel(rx_sel), .rx_bits(rx_bits), .rx_crc_bad(ev[9]),
      .rx_third_packet(ev[10]), .rx_overflow(ev[11]), .rx_underflow(ev[12]),
      .pa_enabled(pa_en), .rx_enabled(rx_en), .pll_unlock_pin(pll), .irq(irq));
   task stop_test;
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk("read data", reg_rdata, e);
   endtask
   task setm(input logic [31:0] m);
      for (int k = 0; k < 4; k++) wr(`RPET_ADDR_MASK0 + k, m[k*8 +: 8]);
   endtask
   task clr;
      for (int k = 0; k < 4; k++) wr(`RPET_ADDR_PEND0 + k, 8'hFF);
   endtask
   task pulse(input integer x);
      @(posedge clk) ev[x] <= 1'b1;
      @(posedge clk) ev[x] <= 1'b0;
   endtask
   task host_tx(input logic s, input logic [15:0] b);
      integer k;
      @(posedge clk) begin h_go <= 1'b1; h_sel <= s; h_bits <= b; end
      @(posedge clk) h_go <= 1'b0;
      k = 0;
      while (k < 4 && cmd_tx_on !== 1'b1) begin
         @(posedge clk);
         k = k + 1;
      end
      chk("transmit-on after load", k < 4, 1);
   endtask
   // Counts edges from the launching edge until irq is seen high
   task waitc(input integer e, input integer tol);
      integer n;
      n = 0;
      // Bounded like the host's abort timer
      while (n <= e + tol && irq !== 1'b1) begin
         @(posedge clk);
         #1 n = n + 1;
      end
      chk("irq delay in range", n >= e && n <= e + tol, 1);
      if (irq !== 1'b1) stop_test;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(`RPET_ADDR_AVG, 8'h08);
      wr(`RPET_ADDR_IWAIT_LO, 8'h02);
      rchk(`RPET_ADDR_IWAIT_LO, 8'h02);
      wr(8'h30, 8'hFF);
      rchk(8'h30, 8'h00);
      wr(`RPET_ADDR_CTRL, 8'hFF);
      rchk(`RPET_ADDR_CTRL, 8'h0F);
      wr(`RPET_ADDR_CTRL, 8'h00);
      wr(`RPET_ADDR_ADC_CLK, 8'h10);
      setm(32'h0000_0100);
      pulse(0);
      waitc(12 * 800 + 2, 1);
      clr;
      wr(`RPET_ADDR_CTRL, 8'h02);
      wr(`RPET_ADDR_ADC_CLK, 8'h00);
      cca_busy <= 1'b1;
      pulse(0);
      cca_busy <= 1'b0;
      waitc(10 * 885 + 2, 1);
      for (i = 0; i < 4; i++) begin
         clr;
         setm(32'h0000_0400);
         case (i)
            0: begin host_tx(1'b0, 16'h0010); c = 6100; end
            1: begin state_tx <= 1'b1; pulse(1); c = 7100; end
            2: begin state_tx <= 1'b0; state_rx <= 1'b1; pulse(2); c = 550; end
            default: begin pulse(3); c = 500; end
         endcase
         waitc(c + 1, 0);
      end
      state_rx <= 1'b0;
      clr;
      wr(`RPET_ADDR_CTRL, 8'h0C);
      setm(32'h0002_0000);
      host_tx(1'b1, 16'h0010);
      waitc(16 * 125 + 7700 + 1, 0);
      rchk(`RPET_ADDR_PEND2, 8'h82);
      clr;
      wr(`RPET_ADDR_CTRL, 8'h09);
      setm(32'h0001_0000);
      host_tx(1'b0, 16'h0010);
      waitc(16 * 250 + 11200 + 1, 0);
      rchk(`RPET_ADDR_PEND2, 8'h41);
      clr;
      setm(32'h0040_0000);
      host_tx(1'b0, 16'h0010);
      #1 chk("irq on accept", irq, 1);
      pulse(3);
      clr;
      wr(`RPET_ADDR_CTRL, 8'h04);
      setm(32'h0004_0000);
      rx_bits <= 16'h0008;
      pulse(8);
      rx_bits <= 16'hFFF7;
      waitc(8 * 500 + 250 + 1, 0);
      clr;
      setm(32'h0100_0000);
      rx_bits <= 16'h0008;
      pulse(8);
      rx_bits <= 16'hFFF7;
      waitc(4250 + 4602, 2);
      clr;
      wr(`RPET_ADDR_CTRL, 8'h0D);
      setm(32'h0020_0000);
      rx_sel <= 1'b1;
      rx_bits <= 16'h0004;
      pulse(8);
      rx_bits <= 16'hFFFB;
      pulse(9);
      waitc(4 * 2 * 125 + 15750 + 1 - 2, 0);
      rchk(`RPET_ADDR_PEND2, 8'h20);
      setm(32'h0000_E000);
      for (i = 4; i < 13; i++) begin
         if (i == 8) i = 10;
         clr;
         pulse(i);
         rchk(`RPET_ADDR_PEND1, i == 4 ? 8'h20 : (i < 8 ? 8'h80 : 8'h40));
      end
      setm(32'h0000_0000);
      clr;
      pulse(4);
      repeat (3) @(posedge clk);
      #1 chk("irq while masked", irq, 0);
      setm(32'h0000_2000);
      repeat (2) @(posedge clk);
      #1 chk("irq after unmask", irq, 1);
      clr;
      setm(32'h0200_0000);
      pll <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk("unlock while idle", irq, 0);
      state_rx <= 1'b1;
      rx_en <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk("unlock while receiving", irq, 1);
      stop_test;
   end
endmodule // test_radio_packet_event_timing
bind rpet_event_timing rpet_event_timing_monitor u_mon (.clk, .reset_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .cmd_tx_on, .state_tx, .state_rx,
   .tx_write_bad_len, .tx_full_written, .tx_buf_sel, .tx_third_packet, .rx_overflow,
   .pll_unlock_pin, .rx_enabled);
